// ### hcr_cmd_status.sv
// command and status register pair with interrupt status/clear/enable
// assumes avalon-mm master holds a request until waitrequest is seen low
module hcr_cmd_status #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // controller state levels
    input wire logic i_halted,
    input wire logic i_not_ready,
    input wire logic i_ctrl_error,
    input wire logic i_save_busy,
    input wire logic i_restore_busy,
    // controller event pulses
    input wire logic i_sys_error_evt,
    input wire logic i_event_evt,
    input wire logic i_port_change_evt,
    input wire logic i_save_restore_err_evt,
    // command outputs
    output logic o_run_stop,
    output logic o_full_ctrl_reset,
    output logic o_interrupter_en,
    output logic o_sys_error_report_en,
    output logic o_light_ctrl_reset,
    output logic o_state_save_cmd,
    output logic o_state_restore_cmd,
    output logic o_wrap_event_en,
    output logic o_suspend_index_stop_en,
    // interrupt
    output logic o_irq
);

    // ********************************************
    // reset synchroniser
    // ********************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rst_sync_ff <= 2'h0;
        else if (i_clk_en)
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // ********************************************
    // bus handshake
    // ********************************************
    hcr_pkg::hcr_bus_t bus_ff;
    hcr_pkg::hcr_bus_t nxt_bus;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic req;
    logic done;
    logic wr_done;
    logic rd_done;
    logic [7:0] addr;
    logic [31:0] be_mask;

    // registers
    logic [31:0] cmd_ff;
    logic [31:0] nxt_cmd;
    logic [31:0] sts_ff;
    logic [31:0] nxt_sts;
    logic [hcr_pkg::EVT_W-1:0] irq_sts_ff;
    logic [hcr_pkg::EVT_W-1:0] nxt_irq_sts;
    logic [hcr_pkg::EVT_W-1:0] irq_en_ff;
    logic [hcr_pkg::EVT_W-1:0] nxt_irq_en;
    logic [hcr_pkg::EVT_W-1:0] evt;

    assign addr = 8'(i_avs_address);
    assign req = i_avs_read | i_avs_write;
    // one wait cycle: read data comes from a flop loaded in the first cycle
    assign o_avs_waitrequest = req & (bus_ff != hcr_pkg::BUS_DONE);
    assign done = req & (bus_ff == hcr_pkg::BUS_DONE);
    assign wr_done = done & i_avs_write;
    assign rd_done = done & i_avs_read;
    assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign evt = {i_save_restore_err_evt, i_port_change_evt, i_event_evt, i_sys_error_evt};

    always_comb
    begin
        nxt_bus = bus_ff;
        nxt_rdata = rdata_ff;
        case (bus_ff)
            hcr_pkg::BUS_IDLE:
            begin
                if (req)
                    nxt_bus = hcr_pkg::BUS_DONE;
                if (i_avs_read)
                begin
                    case (addr)
                        hcr_pkg::CMD_OFS: nxt_rdata = cmd_ff & hcr_pkg::CMD_RW_MASK;
                        hcr_pkg::STS_OFS: nxt_rdata = sts_ff & hcr_pkg::STS_DEF_MASK;
                        hcr_pkg::IRQ_STS_OFS: nxt_rdata = 32'(irq_sts_ff);
                        hcr_pkg::IRQ_EN_OFS: nxt_rdata = 32'(irq_en_ff);
                        default: nxt_rdata = 32'h0000_0000;
                    endcase
                end
            end
            hcr_pkg::BUS_DONE: nxt_bus = hcr_pkg::BUS_IDLE;
            default: nxt_bus = hcr_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_ff <= hcr_pkg::BUS_IDLE;
            rdata_ff <= 32'h0000_0000;
        end
        else if (i_clk_en)
        begin
            bus_ff <= nxt_bus;
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_avs_readdata = rdata_ff;

    // ********************************************
    // command register
    // ********************************************
    always_comb
    begin
        nxt_cmd = cmd_ff;
        if (wr_done && addr == hcr_pkg::CMD_OFS)
            nxt_cmd = ((cmd_ff & ~be_mask) | (i_avs_writedata & be_mask))
                      & hcr_pkg::CMD_RW_MASK;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_ff <= hcr_pkg::CMD_RESET;
        else if (i_clk_en)
            cmd_ff <= nxt_cmd;
    end

    assign o_run_stop = cmd_ff[hcr_pkg::CMD_RUN_STOP];
    assign o_full_ctrl_reset = cmd_ff[hcr_pkg::CMD_FULL_RST];
    assign o_interrupter_en = cmd_ff[hcr_pkg::CMD_INTR_EN];
    assign o_sys_error_report_en = cmd_ff[hcr_pkg::CMD_SYS_ERR_EN];
    assign o_light_ctrl_reset = cmd_ff[hcr_pkg::CMD_LIGHT_RST];
    assign o_state_save_cmd = cmd_ff[hcr_pkg::CMD_SAVE];
    assign o_state_restore_cmd = cmd_ff[hcr_pkg::CMD_RESTORE];
    assign o_wrap_event_en = cmd_ff[hcr_pkg::CMD_WRAP_EN];
    assign o_suspend_index_stop_en = cmd_ff[hcr_pkg::CMD_SUSP_STOP_EN];

    // ********************************************
    // status register
    // ********************************************
    always_comb
    begin
        nxt_sts = 32'h0000_0000;
        // read-only levels sampled one cycle late
        nxt_sts[hcr_pkg::STS_HALTED] = i_halted;
        nxt_sts[hcr_pkg::STS_NOT_READY] = i_not_ready;
        nxt_sts[hcr_pkg::STS_SAVE_BUSY] = i_save_busy;
        nxt_sts[hcr_pkg::STS_RESTORE_BUSY] = i_restore_busy;
        nxt_sts[hcr_pkg::STS_CTRL_ERR] = i_ctrl_error;
        // sticky flags: cleared by a completed read, a new event wins
        nxt_sts[hcr_pkg::STS_SYS_ERR] = sts_ff[hcr_pkg::STS_SYS_ERR];
        nxt_sts[hcr_pkg::STS_EVENT] = sts_ff[hcr_pkg::STS_EVENT];
        nxt_sts[hcr_pkg::STS_PORT_CHG] = sts_ff[hcr_pkg::STS_PORT_CHG];
        nxt_sts[hcr_pkg::STS_SR_ERR] = sts_ff[hcr_pkg::STS_SR_ERR];
        // only flags the read returned are cleared: one that rose during
        // the wait cycle was never seen by software and must stay pending
        if (rd_done && addr == hcr_pkg::STS_OFS)
            nxt_sts = nxt_sts & ~(rdata_ff & 32'h0000_041C);
        if (evt[hcr_pkg::EVT_SYS_ERR])
            nxt_sts[hcr_pkg::STS_SYS_ERR] = 1'b1;
        if (evt[hcr_pkg::EVT_EVENT])
            nxt_sts[hcr_pkg::STS_EVENT] = 1'b1;
        if (evt[hcr_pkg::EVT_PORT_CHG])
            nxt_sts[hcr_pkg::STS_PORT_CHG] = 1'b1;
        if (evt[hcr_pkg::EVT_SR_ERR])
            nxt_sts[hcr_pkg::STS_SR_ERR] = 1'b1;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sts_ff <= hcr_pkg::STS_RESET;
        else if (i_clk_en)
            sts_ff <= nxt_sts;
    end

    // ********************************************
    // interrupt status, clear, enable
    // ********************************************
    always_comb
    begin
        nxt_irq_sts = irq_sts_ff;
        nxt_irq_en = irq_en_ff;
        if (wr_done && addr == hcr_pkg::IRQ_CLR_OFS)
            nxt_irq_sts = irq_sts_ff & ~i_avs_writedata[hcr_pkg::EVT_W-1:0];
        // set after clear so a same-cycle event is kept
        nxt_irq_sts = nxt_irq_sts | evt;
        if (wr_done && addr == hcr_pkg::IRQ_EN_OFS && i_avs_byteenable[0])
            nxt_irq_en = i_avs_writedata[hcr_pkg::EVT_W-1:0];
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_sts_ff <= '0;
            irq_en_ff <= '0;
        end
        else if (i_clk_en)
        begin
            irq_sts_ff <= nxt_irq_sts;
            irq_en_ff <= nxt_irq_en;
        end
    end
    assign o_irq = |(irq_sts_ff & irq_en_ff);

    // ********************************************
    // assertions
    // ********************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd_sts;
        i_clk_en && rd_done && addr == hcr_pkg::STS_OFS;
    endsequence

    sequence s_no_evt;
        evt == '0;
    endsequence

    property p_cmd_reset;
        $rose(rst_n) |-> cmd_ff == hcr_pkg::CMD_RESET;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset) else $error("command not zero after reset");

    property p_rsvd_zero;
        done |-> (o_avs_readdata & ~hcr_pkg::CMD_RW_MASK & ~hcr_pkg::STS_DEF_MASK
                  & ~32'h0000_000F) == 32'h0000_0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

    property p_cmd_write;
        i_clk_en && wr_done && addr == hcr_pkg::CMD_OFS && i_avs_byteenable == 4'hF
        |=> cmd_ff == ($past(i_avs_writedata) & hcr_pkg::CMD_RW_MASK);
    endproperty
    a_cmd_write: assert property (p_cmd_write) else $error("command write not stored");

    property p_cmd_outs;
        i_clk_en && wr_done && addr == hcr_pkg::CMD_OFS && i_avs_byteenable[1:0] == 2'h3
        |=> {o_suspend_index_stop_en, o_wrap_event_en, o_state_restore_cmd,
             o_state_save_cmd, o_light_ctrl_reset} == $past(i_avs_writedata[11:7]);
    endproperty
    a_cmd_outs: assert property (p_cmd_outs) else $error("command outputs mismatch");

    property p_cmd_high_zero;
        cmd_ff[31:12] == 20'h0_0000;
    endproperty
    a_cmd_high_zero: assert property (p_cmd_high_zero) else $error("command high bits set");

    property p_sts_read;
        i_clk_en && o_avs_waitrequest && i_avs_read && addr == hcr_pkg::STS_OFS
        ##1 done |-> o_avs_readdata == ($past(sts_ff) & hcr_pkg::STS_DEF_MASK);
    endproperty
    a_sts_read: assert property (p_sts_read) else $error("status read data wrong");

    property p_sts_reset;
        $rose(rst_n) |-> sts_ff == hcr_pkg::STS_RESET;
    endproperty
    a_sts_reset: assert property (p_sts_reset) else $error("status not 801h after reset");

    property p_rc_clear;
        s_rd_sts and s_no_evt
        |=> (sts_ff & $past(o_avs_readdata) & 32'h0000_041C) == 32'h0000_0000;
    endproperty
    a_rc_clear: assert property (p_rc_clear) else $error("flag not cleared by read");

    property p_evt_wins;
        i_clk_en && i_port_change_evt |=> sts_ff[hcr_pkg::STS_PORT_CHG]
                                          && irq_sts_ff[hcr_pkg::EVT_PORT_CHG];
    endproperty
    a_evt_wins: assert property (p_evt_wins) else $error("event lost");

    property p_ro_track;
        i_clk_en |=> sts_ff[hcr_pkg::STS_CTRL_ERR] == $past(i_ctrl_error)
                     && sts_ff[hcr_pkg::STS_SAVE_BUSY] == $past(i_save_busy);
    endproperty
    a_ro_track: assert property (p_ro_track) else $error("read-only flag mismatch");

    property p_sts_write_no_effect;
        i_clk_en && wr_done && addr == hcr_pkg::STS_OFS
        |=> (sts_ff & $past(sts_ff) & 32'h0000_041C) == ($past(sts_ff) & 32'h0000_041C);
    endproperty
    a_sts_write_no_effect: assert property (p_sts_write_no_effect) else $error("status write acted");

endmodule

// ### hcr_cmd_status_test.sv
// self-checking bench for the command/status register pair
// assumes the design's avalon-mm port and the constants of hcr_pkg
module hcr_cmd_status_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************************
    // signals
    // ********************************************
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    // restore busy, save busy, ctrl error, not ready, halted
    logic [4:0] lvl = 5'h03;
    logic [3:0] evt = 4'h0;
    wire logic [8:0] cmd_o;
    logic irq;
    logic [31:0] cmd_exp = 32'h0000_0000;
    logic [31:0] got;
    int err_total = 0;
    int comparisons = 0;

    always #2 ref_clk = ~ref_clk;

    hcr_cmd_status hcr_cmd_status_i (
        .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_clk_en(1'b1),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_halted(lvl[0]), .i_not_ready(lvl[1]), .i_ctrl_error(lvl[2]),
        .i_save_busy(lvl[3]), .i_restore_busy(lvl[4]),
        .i_sys_error_evt(evt[0]), .i_event_evt(evt[1]),
        .i_port_change_evt(evt[2]), .i_save_restore_err_evt(evt[3]),
        .o_run_stop(cmd_o[0]), .o_full_ctrl_reset(cmd_o[1]),
        .o_interrupter_en(cmd_o[2]), .o_sys_error_report_en(cmd_o[3]),
        .o_light_ctrl_reset(cmd_o[4]), .o_state_save_cmd(cmd_o[5]),
        .o_state_restore_cmd(cmd_o[6]), .o_wrap_event_en(cmd_o[7]),
        .o_suspend_index_stop_en(cmd_o[8]), .o_irq(irq)
    );

    // ********************************************
    // expectations
    // ********************************************
    function automatic logic [31:0] merge_cmd(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] b);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h0000_0F8F;
        return (old & ~m) | (d & m);
    endfunction

    // f: save/restore error, port change, event, system error
    function automatic logic [31:0] sts_val(input logic [4:0] l, input logic [3:0] f);
        return {19'h0, l[2], l[1], f[3], l[4], l[3], 3'h0, f[2], f[1], f[0], 1'b0, l[0]};
    endfunction

    // ********************************************
    // checks and bus cycles
    // ********************************************
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // waitrequest and readdata are read right after the rising edge, before
    // the design's flops update, so they are the values that edge sampled
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] b, output logic [31:0] q);
        int n;
        logic w;
        n = 0;
        @(posedge ref_clk);
        addr <= a;
        wr <= is_wr;
        rd <= !is_wr;
        wdata <= d;
        be <= b;
        do
        begin
            @(posedge ref_clk);
            n++;
            w = waitreq;
        end
        while (w !== 1'b0 && n < 20);
        q = rdata;
        if (w !== 1'b0)
        begin
            err_total++;
            end_sim();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic cmd_step(input logic [31:0] d, input logic [3:0] b);
        bus(1'b1, hcr_pkg::CMD_OFS, d, b, got);
        cmd_exp = merge_cmd(cmd_exp, d, b);
        bus(1'b0, hcr_pkg::CMD_OFS, 32'h0, 4'hF, got);
        chk_word(got, cmd_exp);
        chk_word({23'h0, cmd_o}, {23'h0, cmd_exp[11:7], cmd_exp[3:0]});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF, got);
        chk_word(got, e);
    endtask

    task automatic pulse(input logic [3:0] e);
        @(posedge ref_clk);
        evt <= e;
        @(posedge ref_clk);
        evt <= 4'h0;
    endtask

    // ********************************************
    // main sequence
    // ********************************************
    initial
    begin
        logic [3:0] e;
        void'($urandom(11));
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(hcr_pkg::CMD_OFS, 32'h0000_0000);
        rd_chk(hcr_pkg::STS_OFS, 32'h0000_0801);
        rd_chk(hcr_pkg::IRQ_EN_OFS, 32'h0000_0000);
        chk_flag(irq, 1'b0);
        cmd_step(32'hFFFF_FFFF, 4'hF);
        cmd_step(32'hFFFF_F07F, 4'hF);
        cmd_step(32'h0000_0070, 4'h1);
        repeat (24)
            cmd_step($urandom(), 4'($urandom()));
        bus(1'b1, hcr_pkg::STS_OFS, 32'hFFFF_FFFF, 4'hF, got);
        rd_chk(hcr_pkg::STS_OFS, sts_val(lvl, 4'h0));
        bus(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF, got);
        rd_chk(8'h20, 32'h0000_0000);
        rd_chk(hcr_pkg::CMD_OFS, cmd_exp);
        // state levels show in status
        repeat (10)
        begin
            @(posedge ref_clk);
            lvl <= 5'($urandom());
            repeat (2) @(posedge ref_clk);
            rd_chk(hcr_pkg::STS_OFS, sts_val(lvl, 4'h0));
        end
        // each event: flag set, cleared by the read, irq raised and cleared
        bus(1'b1, hcr_pkg::IRQ_EN_OFS, 32'h0000_000F, 4'h1, got);
        rd_chk(hcr_pkg::IRQ_EN_OFS, 32'h0000_000F);
        for (int i = 0; i < 4; i++)
        begin
            e = 4'h1 << i;
            pulse(e);
            #1;
            chk_flag(irq, 1'b1);
            rd_chk(hcr_pkg::STS_OFS, sts_val(lvl, e));
            rd_chk(hcr_pkg::STS_OFS, sts_val(lvl, 4'h0));
            rd_chk(hcr_pkg::IRQ_STS_OFS, {28'h0, e});
            bus(1'b1, hcr_pkg::IRQ_CLR_OFS, {28'h0, e}, 4'hF, got);
            rd_chk(hcr_pkg::IRQ_STS_OFS, 32'h0000_0000);
            chk_flag(irq, 1'b0);
        end
        // masked events keep status but hold the interrupt low
        bus(1'b1, hcr_pkg::IRQ_EN_OFS, 32'h0000_0000, 4'h1, got);
        pulse(4'hF);
        #1;
        chk_flag(irq, 1'b0);
        rd_chk(hcr_pkg::IRQ_STS_OFS, 32'h0000_000F);
        rd_chk(hcr_pkg::IRQ_CLR_OFS, 32'h0000_0000);
        rd_chk(hcr_pkg::STS_OFS, sts_val(lvl, 4'hF));
        bus(1'b1, hcr_pkg::IRQ_EN_OFS, 32'h0000_0004, 4'h1, got);
        #1;
        chk_flag(irq, 1'b1);
        bus(1'b1, hcr_pkg::IRQ_CLR_OFS, 32'h0000_0004, 4'hF, got);
        #1;
        chk_flag(irq, 1'b0);
        rd_chk(hcr_pkg::IRQ_STS_OFS, 32'h0000_000B);
        end_sim();
    end
endmodule

// ### hcr_pkg.sv
// constants for the host controller command and status register pair
// assumes a 32-bit avalon-mm slave port with byte addressing
package hcr_pkg;

    // ********************************************
    // register offsets (byte addresses)
    // ********************************************
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STS_OFS = 8'h40;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h44;
    localparam logic [7:0] IRQ_EN_OFS = 8'h48;

    // ********************************************
    // command register fields
    // ********************************************
    localparam int CMD_RUN_STOP = 0;
    localparam int CMD_FULL_RST = 1;
    localparam int CMD_INTR_EN = 2;
    localparam int CMD_SYS_ERR_EN = 3;
    localparam int CMD_LIGHT_RST = 7;
    localparam int CMD_SAVE = 8;
    localparam int CMD_RESTORE = 9;
    localparam int CMD_WRAP_EN = 10;
    localparam int CMD_SUSP_STOP_EN = 11;
    localparam logic [31:0] CMD_RW_MASK = 32'h0000_0F8F;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;

    // ********************************************
    // status register fields
    // ********************************************
    localparam int STS_HALTED = 0;
    localparam int STS_SYS_ERR = 2;
    localparam int STS_EVENT = 3;
    localparam int STS_PORT_CHG = 4;
    localparam int STS_SAVE_BUSY = 8;
    localparam int STS_RESTORE_BUSY = 9;
    localparam int STS_SR_ERR = 10;
    localparam int STS_NOT_READY = 11;
    localparam int STS_CTRL_ERR = 12;
    localparam logic [31:0] STS_DEF_MASK = 32'h0000_1F1D;
    localparam logic [31:0] STS_RESET = 32'h0000_0801;

    // ********************************************
    // interrupt event bit layout
    // ********************************************
    localparam int EVT_W = 4;
    localparam int EVT_SYS_ERR = 0;
    localparam int EVT_EVENT = 1;
    localparam int EVT_PORT_CHG = 2;
    localparam int EVT_SR_ERR = 3;

    typedef enum logic {BUS_IDLE, BUS_DONE} hcr_bus_t;

endpackage
